// ==== common/exec_pkg.sv ====
package exec_pkg;
    localparam int PC_W = 21;
    localparam int ADDR_W = 12;
    localparam int APB_AW = 12;

    // Opcode prefixes
    localparam logic [7:0] BRANCH_ON_ZERO_OP = 8'hE0;
    localparam logic [6:0] CALL_FIRST_OP = 7'h76;
    localparam logic [3:0] CALL_SECOND_OP = 4'hF;
    localparam logic [6:0] CLEAR_FILE_OP = 7'h35;

    // Program counter steps in bytes
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] CALL_RETURN_STEP = 21'h000004;

    // Data memory addressing
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [7:0] ACCESS_LOW_MAX = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;

    // Quarter phase divider: clocks per quarter minus one
    localparam int QDIV_W = 2;
    localparam logic [QDIV_W-1:0] QDIV_LAST = 2'h1;

    // Register map, byte addresses
    localparam logic [APB_AW-1:0] CTRL_OFFSET = 12'h000;
    localparam logic [APB_AW-1:0] STATUS_OFFSET = 12'h004;
    localparam logic [APB_AW-1:0] PC_OFFSET = 12'h008;
    localparam logic [APB_AW-1:0] SHADOW_OFFSET = 12'h00C;

    // Field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int STAT_EXT_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_ZFWD_BIT = 2;
    localparam int STAT_NOP_BIT = 3;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;
    typedef enum logic {ST_RUN, ST_NOP} exec_state_t;
endpackage : exec_pkg

// ==== common/phase_if.sv ====
interface phase_if;
    import exec_pkg::*;
    logic tick;
    quarter_t q;
    modport src (output tick, output q);
    modport dst (input tick, input q);
endinterface : phase_if

// ==== verilog/quarter_clock.sv ====
module quarter_clock
    import exec_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    phase_if.src ph
);
    typedef struct packed {
        logic [QDIV_W-1:0] cnt;
        quarter_t q;
        logic tick;
    } qstate_t;

    // Starts in the last quarter so the first enable is a first quarter
    localparam qstate_t QS_RESET = '{cnt: '0, q: Q4, tick: 1'b0};

    qstate_t s_reg;
    qstate_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == QDIV_LAST) begin
            s_next.cnt = '0;
            s_next.tick = 1'b1;
            s_next.q = quarter_t'(s_reg.q + 2'h1);
        end else begin
            s_next.cnt = s_reg.cnt + {{(QDIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_reg <= QS_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ph.tick = s_reg.tick;
    assign ph.q = s_reg.q;
endmodule : quarter_clock

// ==== verilog/file_address.sv ====
module file_address
    import exec_pkg::*;
(
    input wire logic bank_bit,
    input wire logic [7:0] file_sel,
    input wire logic [3:0] bank_select_register,
    input wire logic ext_enable,
    input wire logic [ADDR_W-1:0] index_base,
    output logic [ADDR_W-1:0] addr,
    output logic indexed
);
    always_comb begin
        indexed = 1'b0;
        if (bank_bit) begin
            addr = {bank_select_register, file_sel};
        end else if (ext_enable && file_sel <= INDEXED_MAX) begin
            indexed = 1'b1;
            addr = index_base + {4'h0, file_sel};
        end else if (file_sel <= ACCESS_LOW_MAX) begin
            addr = {ACCESS_LOW_BANK, file_sel};
        end else begin
            addr = {ACCESS_HIGH_BANK, file_sel};
        end
    end
endmodule : file_address

// ==== verilog/branch_call_clear_exec.sv ====
module branch_call_clear_exec
    import exec_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_next,
    output logic instr_taken,
    input wire logic zero_flag_in,
    input wire logic [7:0] working_in,
    input wire logic [7:0] status_in,
    input wire logic [3:0] bank_select_register,
    input wire logic [ADDR_W-1:0] index_base,
    output logic [PC_W-1:0] pc,
    output logic pc_load,
    output logic push_valid,
    output logic [PC_W-1:0] top_of_return_stack,
    output logic shadow_save,
    output logic [7:0] working_shadow,
    output logic [7:0] status_shadow,
    output logic [3:0] bank_select_shadow,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_indexed,
    output logic zero_set
);
    typedef struct packed {
        exec_state_t st;
        logic have_op;
        logic [15:0] op;
        logic [15:0] op2;
        logic [PC_W-1:0] pc;
        logic ext_en;
        logic call_err;
        logic z_fwd;
        logic [7:0] ws;
        logic [7:0] ss;
        logic [3:0] bs;
        logic push_v;
        logic [PC_W-1:0] push_a;
        logic pc_ld;
        logic sh_v;
        logic we;
        logic [ADDR_W-1:0] wa;
        logic widx;
        logic z_set;
        logic [31:0] rdata;
    } exec_t;

    exec_t s_reg;
    exec_t s_next;

    phase_if ph ();

    quarter_clock u_quarter (
        .clock(clock),
        .srst(srst),
        .ph(ph.src)
    );

    logic [ADDR_W-1:0] clr_addr;
    logic clr_indexed;

    file_address u_addr (
        .bank_bit(s_reg.op[8]),
        .file_sel(s_reg.op[7:0]),
        .bank_select_register(bank_select_register),
        .ext_enable(s_reg.ext_en),
        .index_base(index_base),
        .addr(clr_addr),
        .indexed(clr_indexed)
    );

    // Decode of the held opcode
    logic is_branch;
    logic is_call;
    logic is_clear;
    logic call_word2_ok;
    logic zero_seen;
    logic [PC_W-1:0] pc_incr;
    logic [PC_W-1:0] branch_disp;
    logic [PC_W-1:0] call_target;

    assign is_branch = s_reg.have_op && s_reg.op[15:8] == BRANCH_ON_ZERO_OP;
    assign is_call = s_reg.have_op && s_reg.op[15:9] == CALL_FIRST_OP;
    assign is_clear = s_reg.have_op && s_reg.op[15:9] == CLEAR_FILE_OP;
    assign call_word2_ok = s_reg.op2[15:12] == CALL_SECOND_OP;
    // Own clear just committed sets Z before the core's flag catches up
    assign zero_seen = s_reg.z_fwd | zero_flag_in;
    assign pc_incr = s_reg.pc + PC_STEP;
    assign branch_disp = {{(PC_W-9){s_reg.op[7]}}, s_reg.op[7:0], 1'b0};
    assign call_target = {s_reg.op2[11:0], s_reg.op[7:0], 1'b0};

    // APB decode
    logic apb_setup;
    logic apb_access;
    logic addr_hit;
    logic wr_ctrl;
    logic wr_status;
    logic wr_pc;

    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign addr_hit = paddr == CTRL_OFFSET || paddr == STATUS_OFFSET
        || paddr == PC_OFFSET || paddr == SHADOW_OFFSET;
    assign wr_ctrl = apb_access && pwrite && paddr == CTRL_OFFSET;
    assign wr_status = apb_access && pwrite && paddr == STATUS_OFFSET;
    assign wr_pc = apb_access && pwrite && paddr == PC_OFFSET;

    logic err_event;
    logic q1_tick;
    logic q3_tick;
    logic q4_tick;

    assign q1_tick = ph.tick && ph.q == Q1;
    assign q3_tick = ph.tick && ph.q == Q3;
    assign q4_tick = ph.tick && ph.q == Q4;
    assign err_event = q4_tick && is_call && !call_word2_ok;

    always_comb begin
        s_next = s_reg;
        s_next.push_v = 1'b0;
        s_next.pc_ld = 1'b0;
        s_next.sh_v = 1'b0;
        s_next.we = 1'b0;
        s_next.z_set = 1'b0;

        // Software side: control, sticky error clear, PC preset
        if (wr_ctrl) begin
            s_next.ext_en = pwdata[CTRL_EXT_BIT];
        end
        if (wr_status && pwdata[STAT_ERR_BIT]) begin
            s_next.call_err = 1'b0;
        end
        if (wr_pc) begin
            s_next.pc = pwdata[PC_W-1:0];
        end
        // Set wins over a clear in the same cycle
        if (err_event) begin
            s_next.call_err = 1'b1;
        end

        // Read data captured in setup, held through the access phase
        if (apb_setup) begin
            case (paddr)
                CTRL_OFFSET: begin
                    s_next.rdata = '0;
                    s_next.rdata[CTRL_EXT_BIT] = s_reg.ext_en;
                end
                STATUS_OFFSET: begin
                    s_next.rdata = '0;
                    s_next.rdata[STAT_EXT_BIT] = s_reg.ext_en;
                    s_next.rdata[STAT_ERR_BIT] = s_reg.call_err;
                    s_next.rdata[STAT_ZFWD_BIT] = s_reg.z_fwd;
                    s_next.rdata[STAT_NOP_BIT] = s_reg.st == ST_NOP;
                end
                PC_OFFSET: begin
                    s_next.rdata = {{(32-PC_W){1'b0}}, s_reg.pc};
                end
                SHADOW_OFFSET: begin
                    s_next.rdata = {12'h000, s_reg.bs, s_reg.ss, s_reg.ws};
                end
                default: begin
                    s_next.rdata = '0;
                end
            endcase
        end

        // Q1: decode, take the next word unless in a nop cycle
        if (q1_tick) begin
            s_next.have_op = 1'b0;
            if (s_reg.st == ST_RUN && instr_valid) begin
                s_next.have_op = 1'b1;
                s_next.op = instr_word;
                s_next.op2 = instr_next;
            end
        end

        // Q3: push return address and shadow copy
        if (q3_tick && is_call) begin
            s_next.push_v = 1'b1;
            s_next.push_a = s_reg.pc + CALL_RETURN_STEP;
            if (s_reg.op[8]) begin
                s_next.sh_v = 1'b1;
                s_next.ws = working_in;
                s_next.ss = status_in;
                s_next.bs = bank_select_register;
            end
        end

        // Q4: write PC or memory; nop cycle ends here
        if (q4_tick) begin
            if (s_reg.st == ST_NOP) begin
                s_next.st = ST_RUN;
            end else if (s_reg.have_op) begin
                s_next.z_fwd = 1'b0;
                s_next.pc_ld = 1'b1;
                s_next.pc = pc_incr;
                if (is_branch && zero_seen) begin
                    s_next.pc = pc_incr + branch_disp;
                    s_next.st = ST_NOP;
                end else if (is_call && call_word2_ok) begin
                    s_next.pc = call_target;
                    s_next.st = ST_NOP;
                end else if (is_clear) begin
                    s_next.we = 1'b1;
                    s_next.wa = clr_addr;
                    s_next.widx = clr_indexed;
                    s_next.z_set = 1'b1;
                    s_next.z_fwd = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Zero wait state: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_hit;
    assign prdata = s_reg.rdata;

    assign instr_taken = q1_tick && s_reg.st == ST_RUN && instr_valid;
    assign pc = s_reg.pc;
    assign pc_load = s_reg.pc_ld;
    assign push_valid = s_reg.push_v;
    assign top_of_return_stack = s_reg.push_a;
    assign shadow_save = s_reg.sh_v;
    assign working_shadow = s_reg.ws;
    assign status_shadow = s_reg.ss;
    assign bank_select_shadow = s_reg.bs;
    assign mem_we = s_reg.we;
    assign mem_addr = s_reg.wa;
    assign mem_wdata = CLEAR_VALUE;
    assign mem_indexed = s_reg.widx;
    assign zero_set = s_reg.z_set;
endmodule : branch_call_clear_exec

// ==== tb/exec_monitor.sv ====
module exec_monitor
    import exec_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_next,
    input wire logic instr_taken,
    input wire logic zero_flag_in,
    input wire logic [3:0] bank_select_register,
    input wire logic [PC_W-1:0] pc,
    input wire logic pc_load,
    input wire logic push_valid,
    input wire logic [PC_W-1:0] top_of_return_stack,
    input wire logic shadow_save,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic zero_set
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire is_call = instr_taken && instr_word[15:9] == CALL_FIRST_OP;
    wire is_bz = instr_taken && instr_word[15:8] == BRANCH_ON_ZERO_OP;
    wire is_clr = instr_taken && instr_word[15:9] == CLEAR_FILE_OP;
    // Next word only after the nop cycle
    sequence s_quiet;
        ##1 !instr_taken [*8] ##1 !instr_taken [*7];
    endsequence
    // Third quarter tick registers, so the push shows one edge later
    sequence s_push;
        ##5 push_valid;
    endsequence
    property p_push;
        is_call |-> s_push ##0 top_of_return_stack == $past(pc, 5) + CALL_RETURN_STEP;
    endproperty
    a_push: assert property (p_push) else $error("push address wrong");
    property p_push_cause;
        push_valid |-> $past(is_call, 5);
    endproperty
    a_push_cause: assert property (p_push_cause) else $error("stray push");
    property p_shadow;
        is_call |-> ##5 shadow_save == $past(instr_word[8], 5);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow save wrong");
    property p_call_pc;
        is_call && instr_next[15:12] == CALL_SECOND_OP |-> ##7 pc_load
            && pc == {$past(instr_next[11:0], 7), $past(instr_word[7:0], 7), 1'b0};
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call target wrong");
    // A call with a valid second word jumps, so a nop cycle follows
    property p_call_nop;
        is_call && instr_next[15:12] == CALL_SECOND_OP |-> s_quiet;
    endproperty
    a_call_nop: assert property (p_call_nop) else $error("call nop missing");
    property p_bz_jump;
        is_bz && zero_flag_in |-> ##7 pc_load && pc == $past(pc, 7) + PC_STEP
            + {{12{$past(instr_word[7], 7)}}, $past(instr_word[7:0], 7), 1'b0};
    endproperty
    a_bz_jump: assert property (p_bz_jump) else $error("branch target wrong");
    property p_bz_nop;
        is_bz && zero_flag_in |-> s_quiet;
    endproperty
    a_bz_nop: assert property (p_bz_nop) else $error("branch nop missing");
    property p_clr;
        is_clr |-> ##7 mem_we && zero_set && mem_wdata == CLEAR_VALUE
            && pc == $past(pc, 7) + PC_STEP;
    endproperty
    a_clr: assert property (p_clr) else $error("clear write wrong");
    property p_bank;
        is_clr && instr_word[8] |-> ##7
            mem_addr == {$past(bank_select_register, 7), $past(instr_word[7:0], 7)};
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");
endmodule : exec_monitor

// ==== tb/tb_top.sv ====
module tb_top
    import exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, e, ext = 0, zfwd = 0;
    logic instr_valid = 0, zero_flag_in = 0;
    logic [11:0] paddr = '0, index_base = '0;
    logic [31:0] pwdata = '0, prdata, rd, rnd = 32'h9522;
    logic [15:0] instr_word = '0, instr_next = '0;
    logic [7:0] working_in = '0, status_in = '0, working_shadow, status_shadow, mem_wdata;
    logic [3:0] bank_select_register = '0, bank_select_shadow;
    logic pready, pslverr, instr_taken, pc_load, push_valid, shadow_save;
    logic mem_we, mem_indexed, zero_set;
    logic [PC_W-1:0] pc, top_of_return_stack, epc = '0;
    logic [ADDR_W-1:0] mem_addr;
    logic [19:0] esh = '0;
    int miscompares = 0, checks_done = 0, cyc = 0;
    always #5 clock = ~clock;
    branch_call_clear_exec dut_u (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .instr_valid, .instr_word, .instr_next, .instr_taken,
        .zero_flag_in, .working_in, .status_in, .bank_select_register, .index_base, .pc,
        .pc_load, .push_valid, .top_of_return_stack, .shadow_save, .working_shadow,
        .status_shadow, .bank_select_shadow, .mem_we, .mem_addr, .mem_wdata, .mem_indexed,
        .zero_set);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr
    function automatic logic [12:0] exp_addr(input logic [15:0] w);
        if (w[8]) return {1'b0, bank_select_register, w[7:0]};
        if (ext && w[7:0] <= 8'h5F) return {1'b1, index_base + {4'h0, w[7:0]}};
        return {1'b0, (w[7:0] <= 8'h5F) ? 4'h0 : 4'hF, w[7:0]};
    endfunction : exp_addr
    task automatic summarize;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // Answer taken at the very edge where pready is seen high
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic ins(input logic [15:0] w, input logic [15:0] nx, input logic z);
        logic [PC_W-1:0] old;
        @(posedge clock);
        instr_valid <= 1;
        instr_word <= w;
        instr_next <= nx;
        zero_flag_in <= z;
        {index_base, bank_select_register, status_in, working_in} <= rnd;
        do @(posedge clock); while (instr_taken !== 1'b1);
        instr_valid <= 0;
        old = epc;
        // Own clear counts as zero set
        if (w[15:8] == 8'hE0 && (z || zfwd)) epc = old + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0};
        else if (w[15:9] == 7'h76 && nx[15:12] == 4'hF) epc = {nx[11:0], w[7:0], 1'b0};
        else epc = old + 21'h2;
        zfwd = (w[15:9] == 7'h35);
        if (w[15:9] == 7'h76 && w[8]) esh = {rnd[7:0], rnd[15:8], rnd[19:16]};
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk("pc", pc, epc);
        if (zfwd) chk("addr", {mem_indexed, mem_addr}, exp_addr(w));
        if (w[15:9] == 7'h76) begin
            chk("tos", top_of_return_stack, old + 21'h4);
            chk("shadow", {working_shadow, status_shadow, bank_select_shadow}, esh);
        end
    endtask : ins
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        srst <= 0;
        apb(0, CTRL_OFFSET, 0);
        chk("ctrl", rd, 0);
        apb(0, STATUS_OFFSET, 0);
        chk("status", rd, 0);
        apb(0, 12'h010, 0);
        chk("slverr", e, 1);
        apb(1, PC_OFFSET, 32'h100);
        epc = 21'h100;
        $display("test regs done");
        ins(16'h6B12, 0, 0);
        apb(0, STATUS_OFFSET, 0);
        chk("zfwd", rd, 32'h4);
        ins(16'hE080, 0, 0);
        ins(16'hE07F, 0, 1);
        ins(16'hE005, 0, 0);
        ins(16'hED34, 16'hF123, 1);
        apb(0, SHADOW_OFFSET, 0);
        chk("shreg", rd, {12'h0, rnd[19:0]});
        ins(16'hEC00, 16'h0123, 0);
        apb(0, STATUS_OFFSET, 0);
        chk("err", rd[1], 1);
        apb(1, STATUS_OFFSET, 2);
        apb(0, STATUS_OFFSET, 0);
        chk("errclr", rd[1], 0);
        ins(16'h6A10, 0, 0);
        apb(1, CTRL_OFFSET, 1);
        ext = 1;
        ins(16'h6A5F, 0, 0);
        ins(16'h6A60, 0, 0);
        $display("test corner done");
        repeat (60) begin
            rnd = lfsr(rnd);
            case (rnd[25:24])
                2'h0: ins({8'hE0, rnd[7:0]}, 0, rnd[26] | zfwd);
                2'h1: ins({7'h76, rnd[8], rnd[7:0]}, {4'hF, rnd[23:12]}, rnd[26] | zfwd);
                default: ins({7'h35, rnd[9], rnd[7:0]}, 0, rnd[26] | zfwd);
            endcase
        end
        $display("test random done");
        summarize();
    end
endmodule : tb_top
bind branch_call_clear_exec exec_monitor mon_u (.clock, .srst, .instr_word, .instr_next,
    .instr_taken, .zero_flag_in, .bank_select_register, .pc, .pc_load, .push_valid,
    .top_of_return_stack, .shadow_save, .mem_we, .mem_addr, .mem_wdata, .zero_set);
